// ---- irq_priority.sv ----
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// R01 - Per-source priority bits count only while priority levels are on
// R02 - Priority levels off gives one-level mode; enable resets to 0, read-write
// R03 - First priority register: converter bit 6 down to timer one bit 0
// R04 - Second priority register: bits 7, 4, 2, 0 implemented, others read 0
// R05 - Third priority register: bits 4 to 0 implemented, 7 to 5 read 0
// R06 - Third register bits 3 and 2 serve capture or encoder, whichever runs
// R07 - All implemented peripheral priority bits reset to 1
// R08 - Reset control holds reset causes with documented resets and access
// R09 - External pins edge-triggered; edge select 1 rising, 0 falling
// R10 - Valid edge sets pin flag; enable gates the request
// R11 - Software clears the pin flag before re-enabling; hardware never does
// R12 - Enabled external pin interrupt wakes from idle or sleep
// R13 - After wake, vector only if global enable set, else resume
// R14 - External one and two priorities from third control bits 6 and 7
// R15 - External zero has no priority bit and is always high
// R16 - Timer zero flag sets on overflow, 8-bit or 16-bit mode
// R17 - Timer zero enable main bit 5, priority second bit 2
// R18 - Port pins 7 to 4 change sets flag bit 0; enable bit 3, priority bit 0
// R19 - Entry saves return address and working, status, bank registers
// R20 - Without priority levels, peripherals also need peripheral enable
// R21 - PWM time-base flag sets on match via postscaler, software clears; here flag bit 15 is outside the writable low byte
// R22 - High-priority request served first and may preempt low service
// R23 - Request raised only when flag, enable and global enables allow
module irq_priority #(
  parameter int NP = irq_pkg::NUM_PERIPH
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_reset,
  input  wire logic [3:0]    i_addr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [7:0]    o_rdata,
  input  wire logic [2:0]    i_ext_pin,
  input  wire logic [3:0]    i_port_hi,
  input  wire logic [NP-1:0] i_periph_event,
  input  wire logic          i_sleeping,
  input  wire logic          i_ack,
  input  wire logic          i_retfie,
  input  wire logic [7:0]    i_work,
  input  wire logic [7:0]    i_status,
  input  wire logic [7:0]    i_bank,
  input  wire logic [7:0]    i_pc,
  output logic               o_irq_high,
  output logic               o_irq_low,
  output logic               o_wake,
  output logic               o_vector
);
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_LOW  = 2'b01,
    SVC_HIGH = 2'b10
  } svc_t;

  logic [7:0]    prio_one;
  logic [7:0]    prio_two;
  logic [7:0]    prio_three;
  logic [7:0]    reset_ctl;
  logic [7:0]    main_ctl;
  logic [7:0]    second_ctl;
  logic [7:0]    third_ctl;
  logic [NP-1:0] periph_flag;
  logic [NP-1:0] periph_en;
  logic [15:0]   timer;
  logic [1:0]    timer_ctl;
  svc_t          svc;
  svc_t          next_svc;
  logic [7:0]    saved_work;
  logic [7:0]    saved_status;
  logic [7:0]    saved_bank;
  logic [7:0]    saved_pc;

  core_ctx_if ctx ();

  logic [2:0] ext_rise;
  logic [2:0] ext_fall;
  logic [3:0] port_rise;
  logic [3:0] port_fall;

  edge_sync #(.WIDTH(3)) u_ext_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_pin     (i_ext_pin),
    .o_level   (),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );

  edge_sync #(.WIDTH(4)) u_port_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_pin     (i_port_hi),
    .o_level   (),
    .o_rise    (port_rise),
    .o_fall    (port_fall)
  );

  ctx_store u_ctx (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .ctx       (ctx),
    .o_work    (saved_work),
    .o_status  (saved_status),
    .o_bank    (saved_bank),
    .o_pc      (saved_pc)
  );

  function automatic logic sel_edge(input logic sel, input logic r, input logic f);
    return sel ? r : f; // R09
  endfunction

  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] r, input logic w);
    return w && (a == r);
  endfunction

  // Write decode
  wire wr_p1   = wr_hit(i_addr, irq_pkg::ADDR_PRIO_ONE, i_wr);
  wire wr_p2   = wr_hit(i_addr, irq_pkg::ADDR_PRIO_TWO, i_wr);
  wire wr_p3   = wr_hit(i_addr, irq_pkg::ADDR_PRIO_THREE, i_wr);
  wire wr_rc   = wr_hit(i_addr, irq_pkg::ADDR_RESET_CTL, i_wr);
  wire wr_mc   = wr_hit(i_addr, irq_pkg::ADDR_MAIN_CTL, i_wr);
  wire wr_sc   = wr_hit(i_addr, irq_pkg::ADDR_SECOND_CTL, i_wr);
  wire wr_tc   = wr_hit(i_addr, irq_pkg::ADDR_THIRD_CTL, i_wr);
  wire wr_pf   = wr_hit(i_addr, irq_pkg::ADDR_PERIPH_FLG, i_wr);
  wire wr_pe   = wr_hit(i_addr, irq_pkg::ADDR_PERIPH_EN, i_wr);
  wire wr_tlo  = wr_hit(i_addr, irq_pkg::ADDR_TIMER_LO, i_wr);
  wire wr_thi  = wr_hit(i_addr, irq_pkg::ADDR_TIMER_HI, i_wr);
  wire wr_tctl = wr_hit(i_addr, irq_pkg::ADDR_TIMER_CTL, i_wr);

  // Edge events from the synchronised pins
  wire [2:0] ext_edge;
  assign ext_edge[0] = sel_edge(second_ctl[irq_pkg::POS_EDGE0], ext_rise[0], ext_fall[0]);
  assign ext_edge[1] = sel_edge(second_ctl[irq_pkg::POS_EDGE1], ext_rise[1], ext_fall[1]);
  assign ext_edge[2] = sel_edge(second_ctl[irq_pkg::POS_EDGE2], ext_rise[2], ext_fall[2]);
  wire port_change = |(port_rise | port_fall); // R18

  // Timer zero; overflow width follows the mode bit
  wire        t_wide   = timer_ctl[irq_pkg::POS_T0_WIDE];
  wire        t_run    = timer_ctl[irq_pkg::POS_T0_RUN];
  wire [15:0] t_next   = timer + 16'h0001;
  wire        t_ovf    = t_run && (t_wide ? (timer == 16'hffff)
                                          : (timer[7:0] == 8'hff)); // R16

  // Flattened peripheral priority vector, order set in the package
  wire [NP-1:0] periph_prio = {prio_three[4:0],
                               prio_two[7], prio_two[4], prio_two[2], prio_two[0],
                               prio_one[6:0]};

  wire prio_on = reset_ctl[irq_pkg::POS_PRIO_LEVELS]; // R01
  wire global_irq_enable     = main_ctl[irq_pkg::POS_GIE];
  wire peripheral_irq_enable    = main_ctl[irq_pkg::POS_PERIPHERAL_IRQ_ENABLE];

  // Pending and enabled per source
  wire          ext0_act = main_ctl[irq_pkg::POS_EXT0_FLG] & main_ctl[irq_pkg::POS_EXT0_EN];
  wire          ext1_act = third_ctl[irq_pkg::POS_EXT1_FLG] & third_ctl[irq_pkg::POS_EXT1_EN];
  wire          ext2_act = third_ctl[irq_pkg::POS_EXT2_FLG] & third_ctl[irq_pkg::POS_EXT2_EN];
  wire          t0_act   = main_ctl[irq_pkg::POS_T0_FLAG] & main_ctl[irq_pkg::POS_T0_EN];
  wire          pc_act   = main_ctl[irq_pkg::POS_PC_FLAG] & main_ctl[irq_pkg::POS_PC_EN];
  wire [NP-1:0] per_act  = periph_flag & periph_en; // R23

  // Split by priority; ext zero is fixed high
  wire hi_src = ext0_act // R15
              | (ext1_act & third_ctl[irq_pkg::POS_EXT1_PRIO]) // R14
              | (ext2_act & third_ctl[irq_pkg::POS_EXT2_PRIO]) // R14
              | (t0_act & second_ctl[irq_pkg::POS_T0_PRIO]) // R17
              | (pc_act & second_ctl[irq_pkg::POS_PC_PRIO]) // R18
              | |(per_act & periph_prio); // R06
  wire lo_src = (ext1_act & ~third_ctl[irq_pkg::POS_EXT1_PRIO])
              | (ext2_act & ~third_ctl[irq_pkg::POS_EXT2_PRIO])
              | (t0_act & ~second_ctl[irq_pkg::POS_T0_PRIO])
              | (pc_act & ~second_ctl[irq_pkg::POS_PC_PRIO])
              | |(per_act & ~periph_prio);

  // In priority mode bit 7 and 6 act as high and low global enables
  wire core_src  = ext0_act | ext1_act | ext2_act | t0_act | pc_act;
  wire flat_req  = global_irq_enable && (core_src || (peripheral_irq_enable && |per_act)); // R02 R20
  wire req_high  = prio_on ? (global_irq_enable && hi_src) : flat_req; // R01 R23
  wire req_low   = prio_on && global_irq_enable && peripheral_irq_enable && lo_src; // R23

  // Wake needs only flag and enable, not the global enable
  wire ext_wake  = ext0_act | ext1_act | ext2_act; // R12
  wire any_wake  = ext_wake | t0_act | pc_act | |per_act;

  // Service state: high preempts low, low never interrupts high
  wire take_high = req_high && (svc != SVC_HIGH); // R22
  wire take_low  = req_low && !req_high && (svc == SVC_IDLE); // R22
  wire entry     = i_ack && (take_high || take_low);

  always_comb begin
    next_svc = svc;
    case (svc)
      SVC_IDLE: begin
        if (entry)
          next_svc = take_high ? SVC_HIGH : SVC_LOW;
      end
      SVC_LOW: begin
        if (entry && take_high)
          next_svc = SVC_HIGH; // R22
        else if (i_retfie)
          next_svc = SVC_IDLE;
      end
      SVC_HIGH: begin
        if (i_retfie)
          next_svc = SVC_IDLE;
      end
      default: next_svc = SVC_IDLE;
    endcase
  end

  assign ctx.entry  = entry; // R19
  assign ctx.work   = i_work;
  assign ctx.status = i_status;
  assign ctx.bank   = i_bank;
  assign ctx.pc     = i_pc;

  // Read decode; unmapped reads give zero
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      irq_pkg::ADDR_PRIO_ONE:   rd_mux = prio_one & irq_pkg::MASK_PRIO_ONE; // R03
      irq_pkg::ADDR_PRIO_TWO:   rd_mux = prio_two & irq_pkg::MASK_PRIO_TWO; // R04
      irq_pkg::ADDR_PRIO_THREE: rd_mux = prio_three & irq_pkg::MASK_PRIO_THREE; // R05
      irq_pkg::ADDR_RESET_CTL:  rd_mux = reset_ctl & irq_pkg::MASK_RESET_CTL; // R08
      irq_pkg::ADDR_MAIN_CTL:   rd_mux = main_ctl;
      irq_pkg::ADDR_SECOND_CTL: rd_mux = second_ctl;
      irq_pkg::ADDR_THIRD_CTL:  rd_mux = third_ctl;
      irq_pkg::ADDR_PERIPH_FLG: rd_mux = periph_flag[7:0];
      irq_pkg::ADDR_PERIPH_EN:  rd_mux = periph_en[7:0];
      irq_pkg::ADDR_TIMER_LO:   rd_mux = timer[7:0];
      irq_pkg::ADDR_TIMER_HI:   rd_mux = timer[15:8];
      irq_pkg::ADDR_TIMER_CTL:  rd_mux = {6'h00, timer_ctl};
      irq_pkg::ADDR_CTX_WORK:   rd_mux = saved_work;
      irq_pkg::ADDR_CTX_STATUS: rd_mux = saved_status;
      irq_pkg::ADDR_CTX_BANK:   rd_mux = saved_bank;
      irq_pkg::ADDR_CTX_PC:     rd_mux = saved_pc;
      default:                  rd_mux = 8'h00;
    endcase
  end

  // Flag registers: a hardware set beats a software clear in the same cycle
  logic [7:0] next_main;
  logic [7:0] next_third;
  always_comb begin
    next_main  = wr_mc ? i_wdata : main_ctl;
    next_third = wr_tc ? (i_wdata & irq_pkg::MASK_THIRD_CTL) : third_ctl;
    if (ext_edge[0])
      next_main[irq_pkg::POS_EXT0_FLG] = 1'b1; // R10
    if (t_ovf)
      next_main[irq_pkg::POS_T0_FLAG] = 1'b1; // R16
    if (port_change)
      next_main[irq_pkg::POS_PC_FLAG] = 1'b1; // R18
    if (ext_edge[1])
      next_third[irq_pkg::POS_EXT1_FLG] = 1'b1; // R10
    if (ext_edge[2])
      next_third[irq_pkg::POS_EXT2_FLG] = 1'b1; // R10
  end

  // Peripheral flags: only the flattened low byte is software visible
  wire [NP-1:0] pf_wr_val = {periph_flag[NP-1:8], i_wdata};
  wire [NP-1:0] pe_wr_val = {periph_en[NP-1:8], i_wdata};
  wire [NP-1:0] next_pflag = (wr_pf ? pf_wr_val : periph_flag) | i_periph_event; // R21

  // Priority, reset-control and enable registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prio_one   <= irq_pkg::MASK_PRIO_ONE; // R07
      prio_two   <= irq_pkg::MASK_PRIO_TWO; // R07
      prio_three <= irq_pkg::MASK_PRIO_THREE; // R07
      reset_ctl  <= irq_pkg::RST_RESET_CTL; // R02 R08
      second_ctl <= irq_pkg::RST_SECOND_CTL;
      periph_en  <= '0;
    end else begin
      if (wr_p1)
        prio_one <= i_wdata & irq_pkg::MASK_PRIO_ONE; // R03
      if (wr_p2)
        prio_two <= i_wdata & irq_pkg::MASK_PRIO_TWO; // R04
      if (wr_p3)
        prio_three <= i_wdata & irq_pkg::MASK_PRIO_THREE; // R05
      if (wr_rc)
        reset_ctl <= (i_wdata & irq_pkg::WMASK_RESET_CTL)
                   | (reset_ctl & ~irq_pkg::WMASK_RESET_CTL); // R08
      if (wr_sc)
        second_ctl <= i_wdata & irq_pkg::MASK_SECOND_CTL;
      if (wr_pe)
        periph_en <= pe_wr_val;
    end
  end

  // Flags, timer and service state
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      main_ctl    <= 8'h00;
      third_ctl   <= irq_pkg::RST_THIRD_CTL;
      periph_flag <= '0;
      timer       <= 16'h0000;
      timer_ctl   <= 2'h0;
      svc         <= SVC_IDLE;
    end else begin
      main_ctl    <= next_main; // R11
      third_ctl   <= next_third; // R11
      periph_flag <= next_pflag;
      svc         <= next_svc;
      if (wr_tctl)
        timer_ctl <= i_wdata[1:0];
      // A software load takes the place of that cycle's count
      if (wr_tlo)
        timer[7:0] <= i_wdata;
      else if (wr_thi)
        timer[15:8] <= i_wdata;
      else if (t_run)
        timer <= t_wide ? t_next : {timer[15:8], t_next[7:0]}; // R16
    end
  end

  // Outputs straight from flops
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata    <= 8'h00;
      o_irq_high <= 1'b0;
      o_irq_low  <= 1'b0;
      o_wake     <= 1'b0;
      o_vector   <= 1'b0;
    end else begin
      o_rdata    <= i_rd ? rd_mux : 8'h00;
      o_irq_high <= take_high;
      o_irq_low  <= take_low;
      o_wake     <= i_sleeping && any_wake; // R12
      o_vector   <= i_sleeping && any_wake && global_irq_enable; // R13
    end
  end
endmodule

// ---- irq_pkg.sv ----
package irq_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADDR_PRIO_ONE   = 4'h0;
  localparam logic [3:0] ADDR_PRIO_TWO   = 4'h1;
  localparam logic [3:0] ADDR_PRIO_THREE = 4'h2;
  localparam logic [3:0] ADDR_RESET_CTL  = 4'h3;
  localparam logic [3:0] ADDR_MAIN_CTL   = 4'h4;
  localparam logic [3:0] ADDR_SECOND_CTL = 4'h5;
  localparam logic [3:0] ADDR_THIRD_CTL  = 4'h6;
  localparam logic [3:0] ADDR_PERIPH_FLG = 4'h7;
  localparam logic [3:0] ADDR_PERIPH_EN  = 4'h8;
  localparam logic [3:0] ADDR_TIMER_LO   = 4'h9;
  localparam logic [3:0] ADDR_TIMER_HI   = 4'ha;
  localparam logic [3:0] ADDR_TIMER_CTL  = 4'hb;
  localparam logic [3:0] ADDR_CTX_WORK   = 4'hc;
  localparam logic [3:0] ADDR_CTX_STATUS = 4'hd;
  localparam logic [3:0] ADDR_CTX_BANK   = 4'he;
  localparam logic [3:0] ADDR_CTX_PC     = 4'hf;

  // Implemented bit masks and reset values
  localparam logic [7:0] MASK_PRIO_ONE   = 8'h7f;
  localparam logic [7:0] MASK_PRIO_TWO   = 8'h95;
  localparam logic [7:0] MASK_PRIO_THREE = 8'h1f;
  localparam logic [7:0] RST_RESET_CTL   = 8'h1c;
  localparam logic [7:0] MASK_RESET_CTL  = 8'h9f;
  localparam logic [7:0] WMASK_RESET_CTL = 8'h93;

  // Reset control field positions
  localparam int POS_PRIO_LEVELS = 7;
  localparam int POS_RESET_INSTR = 4;
  localparam int POS_TIMEOUT     = 3;
  localparam int POS_POWER_DOWN  = 2;
  localparam int POS_POWER_ON    = 1;
  localparam int POS_BROWN_OUT   = 0;

  // Main control field positions
  localparam int POS_GIE      = 7;
  localparam int POS_PERIPHERAL_IRQ_ENABLE     = 6;
  localparam int POS_T0_EN    = 5;
  localparam int POS_EXT0_EN  = 4;
  localparam int POS_PC_EN    = 3;
  localparam int POS_T0_FLAG  = 2;
  localparam int POS_EXT0_FLG = 1;
  localparam int POS_PC_FLAG  = 0;

  // Second control: edge selects 6..4, timer priority 2, port priority 0
  localparam int POS_EDGE0    = 6;
  localparam int POS_EDGE1    = 5;
  localparam int POS_EDGE2    = 4;
  localparam int POS_T0_PRIO  = 2;
  localparam int POS_PC_PRIO  = 0;
  localparam logic [7:0] RST_SECOND_CTL = 8'h75;
  localparam logic [7:0] MASK_SECOND_CTL = 8'h75;

  // Third control: priorities 7,6; enables 4,3; flags 1,0
  localparam int POS_EXT2_PRIO = 7;
  localparam int POS_EXT1_PRIO = 6;
  localparam int POS_EXT2_EN   = 4;
  localparam int POS_EXT1_EN   = 3;
  localparam int POS_EXT2_FLG  = 1;
  localparam int POS_EXT1_FLG  = 0;
  localparam logic [7:0] RST_THIRD_CTL  = 8'hc0;
  localparam logic [7:0] MASK_THIRD_CTL = 8'hdb;

  // Timer control: bit 0 selects 16-bit mode, bit 1 runs the timer
  localparam int POS_T0_WIDE = 0;
  localparam int POS_T0_RUN  = 1;

  // Peripheral sources flattened: one[6:0], two{7,4,2,0}, three[4:0]
  localparam int NUM_PERIPH  = 16;
  localparam int POS_PWM_SRC = 15;
endpackage

// ---- core_ctx_if.sv ----
`timescale 1ns/10ps
interface core_ctx_if;
  logic       entry;
  logic [7:0] work;
  logic [7:0] status;
  logic [7:0] bank;
  logic [7:0] pc;
  modport src (output entry, output work, output status, output bank, output pc);
  modport dst (input entry, input work, input status, input bank, input pc);
endinterface

// ---- edge_sync.sv ----
`timescale 1ns/10ps
module edge_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  // Only the second and third stages feed edge detection
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_level = sync;
  assign o_rise  = sync & ~prev;
  assign o_fall  = ~sync & prev;
endmodule

// ---- ctx_store.sv ----
`timescale 1ns/10ps
module ctx_store (
  input  wire logic    i_clk_sys,
  input  wire logic    i_reset,
  core_ctx_if.dst      ctx,
  output logic [7:0]   o_work,
  output logic [7:0]   o_status,
  output logic [7:0]   o_bank,
  output logic [7:0]   o_pc
);
  // Fast return copy and stacked return address, taken on entry
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_work   <= 8'h00;
      o_status <= 8'h00;
      o_bank   <= 8'h00;
      o_pc     <= 8'h00;
    end else if (ctx.entry) begin
      o_work   <= ctx.work;   // R19
      o_status <= ctx.status; // R19
      o_bank   <= ctx.bank;   // R19
      o_pc     <= ctx.pc;     // R19
    end
  end
endmodule

// ---- irq_priority_chk.sv ----
`timescale 1ns/10ps
module irq_priority_chk #(
  parameter int NP = irq_pkg::NUM_PERIPH
) (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_sleeping,
  input wire logic       i_ack,
  input wire logic [7:0] i_work,
  input wire logic       o_irq_high,
  input wire logic       o_irq_low,
  input wire logic       o_wake,
  input wire logic       o_vector
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // Level enable tracked from the write port, so no internal probe is needed
  logic prio_on;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prio_on <= 1'b0;
    end else if (i_wr && i_addr == irq_pkg::ADDR_RESET_CTL) begin
      prio_on <= i_wdata[7];
    end
  end
  AST_PRIO_ONE: assert property (
    i_wr && i_addr == irq_pkg::ADDR_PRIO_ONE ##1 i_rd && i_addr == irq_pkg::ADDR_PRIO_ONE
    |=> o_rdata == ($past(i_wdata, 2) & irq_pkg::MASK_PRIO_ONE))
    else $error("prio one");
  AST_PRIO_TWO: assert property (
    i_wr && i_addr == irq_pkg::ADDR_PRIO_TWO ##1 i_rd && i_addr == irq_pkg::ADDR_PRIO_TWO
    |=> o_rdata == ($past(i_wdata, 2) & irq_pkg::MASK_PRIO_TWO))
    else $error("prio two");
  AST_PRIO_THREE: assert property (
    i_wr && i_addr == irq_pkg::ADDR_PRIO_THREE ##1 i_rd && i_addr == irq_pkg::ADDR_PRIO_THREE
    |=> o_rdata == ($past(i_wdata, 2) & irq_pkg::MASK_PRIO_THREE))
    else $error("prio three");
  AST_LEVEL_EN: assert property (
    i_wr && i_addr == irq_pkg::ADDR_RESET_CTL ##1 i_rd && i_addr == irq_pkg::ADDR_RESET_CTL
    |=> o_rdata[7] == $past(i_wdata[7], 2))
    else $error("level enable");
  AST_RCTL_GAP: assert property (i_rd && i_addr == irq_pkg::ADDR_RESET_CTL
    |=> o_rdata[6:5] == 2'b00)
    else $error("reset ctl gap");
  AST_WAKE: assert property (o_wake |-> $past(i_sleeping))
    else $error("wake while not sleeping");
  AST_VECTOR: assert property (o_vector |-> o_wake)
    else $error("vector without wake");
  AST_FLAT: assert property (!prio_on ##1 !prio_on |-> !o_irq_low)
    else $error("flat low");
  AST_CTX: assert property (
    i_ack && (o_irq_high || o_irq_low) ##1 i_rd && i_addr == irq_pkg::ADDR_CTX_WORK
    |=> o_rdata == $past(i_work, 2))
    else $error("saved work");
endmodule
bind irq_priority irq_priority_chk #(.NP(NP)) chk (.i_clk_sys, .i_reset, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_sleeping, .i_ack, .i_work, .o_irq_high, .o_irq_low, .o_wake,
  .o_vector);

// ---- core_model.sv ----
`timescale 1ns/10ps
module core_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_req,
  input  wire logic       i_accept,
  input  wire logic [3:0] i_delay,
  output logic            o_ack,
  output logic            o_retfie,
  output logic [7:0]      o_pc,
  output logic [7:0]      o_work,
  output logic [7:0]      o_status,
  output logic [7:0]      o_bank
);
  logic [3:0] wait_cnt;
  logic [3:0] svc_cnt;
  logic       in_svc;
  // Context moves every cycle, so a capture on the wrong edge shows up
  assign o_work   = o_pc ^ 8'h5a;
  assign o_status = o_pc + 8'h33;
  assign o_bank   = {o_pc[3:0], o_pc[7:4]};
  always_ff @(posedge i_clk_sys) begin
    o_ack    <= 1'b0;
    o_retfie <= 1'b0;
    o_pc     <= o_pc + 8'h01;
    if (i_reset) begin
      o_pc     <= 8'h00;
      wait_cnt <= 4'h0;
      svc_cnt  <= 4'h0;
      in_svc   <= 1'b0;
    end else if (in_svc) begin
      svc_cnt  <= svc_cnt + 4'h1;
      in_svc   <= svc_cnt != 4'hf;
      o_retfie <= svc_cnt == 4'hf;
    end else if (i_req && i_accept) begin
      // Slow core: request waits first
      wait_cnt <= (wait_cnt == i_delay) ? 4'h0 : wait_cnt + 4'h1;
      o_ack    <= wait_cnt == i_delay;
      in_svc   <= wait_cnt == i_delay;
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic       clk_sys;
  logic       reset;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [2:0] ext_pin;
  logic [3:0] port_hi;
  logic       sleeping;
  logic       ack;
  logic       retfie;
  logic [7:0] ctx [4];
  logic [7:0] exp_ctx [4];
  logic       irq_high;
  logic       irq_low;
  logic       wake;
  logic       vector;
  logic       accept;
  logic [3:0] delay;
  int         mismatches;
  int         n_compared;
  logic [7:0] rst_val [7];
  logic [3:0] freg [3];
  logic [7:0] fbit [3];

  irq_priority dut (.i_clk_sys(clk_sys), .i_reset(reset), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_pin(ext_pin), .i_port_hi(port_hi),
    .i_periph_event({15'h0000, accept}), .i_sleeping(sleeping), .i_ack(ack), .i_retfie(retfie),
    .i_work(ctx[0]), .i_status(ctx[1]), .i_bank(ctx[2]), .i_pc(ctx[3]),
    .o_irq_high(irq_high), .o_irq_low(irq_low), .o_wake(wake), .o_vector(vector));
  core_model model (.i_clk_sys(clk_sys), .i_reset(reset), .i_req(irq_high | irq_low),
    .i_accept(accept), .i_delay(delay), .o_ack(ack), .o_retfie(retfie), .o_pc(ctx[3]),
    .o_work(ctx[0]), .o_status(ctx[1]), .o_bank(ctx[2]));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string what);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    check(what, rdata & m, e);
    @(posedge clk_sys);
  endtask

  // Back-to-back write and read
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd_chk(a, 8'hff, e, "readback");
  endtask

  task automatic pin_step(input int p, input logic lvl, input logic [7:0] e);
    ext_pin[p] <= lvl;
    repeat (6) @(posedge clk_sys);
    rd_chk(freg[p], fbit[p], e, "pin flag");
    wr_reg(freg[p], 8'h00);
  endtask

  task automatic wait_ack();
    for (int n = 0; n < 40 && ack !== 1'b1; n++) begin
      @(posedge clk_sys);
    end
  endtask

  initial begin
    rst_val = '{8'h7f, 8'h95, 8'h1f, 8'h1c, 8'h00, 8'h75, 8'hc0};
    freg = '{irq_pkg::ADDR_MAIN_CTL, irq_pkg::ADDR_THIRD_CTL, irq_pkg::ADDR_THIRD_CTL};
    fbit = '{8'h02, 8'h01, 8'h02};
    {addr, wdata, wr, rd, ext_pin, port_hi, sleeping, accept, delay} = '0;
    mismatches = 0;
    n_compared = 0;
    reset = 1'b1;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      rd_chk(i[3:0], 8'hff, rst_val[i], "reset value");
    end
    for (int i = 0; i < 3; i++) begin
      wr_rd(i[3:0], 8'haa, 8'haa & rst_val[i]);
      wr_rd(i[3:0], 8'h55, 8'h55 & rst_val[i]);
    end
    wr_rd(irq_pkg::ADDR_RESET_CTL, 8'h00, 8'h0c);
    wr_rd(irq_pkg::ADDR_RESET_CTL, 8'hff, 8'h9f);
    wr_reg(irq_pkg::ADDR_RESET_CTL, 8'h00);
    for (int e = 0; e < 2; e++) begin
      wr_reg(irq_pkg::ADDR_SECOND_CTL, (e == 0) ? 8'h75 : 8'h05);
      for (int p = 0; p < 3; p++) begin
        pin_step(p, 1'b1, (e == 0) ? fbit[p] : 8'h00);
        pin_step(p, 1'b0, (e == 0) ? 8'h00 : fbit[p]);
      end
    end
    port_hi <= 4'h8;
    repeat (6) @(posedge clk_sys);
    rd_chk(irq_pkg::ADDR_MAIN_CTL, 8'h01, 8'h01, "port change");
    wr_reg(irq_pkg::ADDR_TIMER_HI, 8'h00);
    wr_reg(irq_pkg::ADDR_TIMER_LO, 8'hff);
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h03);
    repeat (4) @(posedge clk_sys);
    rd_chk(irq_pkg::ADDR_MAIN_CTL, 8'h04, 8'h00, "wide low wrap");
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h00);
    wr_reg(irq_pkg::ADDR_TIMER_LO, 8'hff);
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h02);
    repeat (4) @(posedge clk_sys);
    rd_chk(irq_pkg::ADDR_MAIN_CTL, 8'h04, 8'h04, "narrow overflow");
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h00);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h00);
    wr_reg(irq_pkg::ADDR_TIMER_HI, 8'hff);
    wr_reg(irq_pkg::ADDR_TIMER_LO, 8'hff);
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h03);
    repeat (4) @(posedge clk_sys);
    rd_chk(irq_pkg::ADDR_MAIN_CTL, 8'h04, 8'h04, "wide overflow");
    wr_reg(irq_pkg::ADDR_TIMER_CTL, 8'h00);
    wr_reg(irq_pkg::ADDR_SECOND_CTL, 8'h75);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h90);
    accept <= 1'b1;
    ext_pin[0] <= 1'b1;
    wait_ack();
    check("ack", {7'h00, ack}, 8'h01);
    check("flat low request", {7'h00, irq_low}, 8'h00);
    exp_ctx = ctx;
    for (int i = 0; i < 4; i++) begin
      rd_chk(4'hc + i[3:0], 8'hff, exp_ctx[i], "saved context");
    end
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h00);
    accept <= 1'b0;
    ext_pin[0] <= 1'b0;
    repeat (20) @(posedge clk_sys);
    sleeping <= 1'b1;
    wr_reg(irq_pkg::ADDR_THIRD_CTL, 8'h08);
    ext_pin[1] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("wake only", {6'h00, wake, vector}, 8'h02);
    check("no global enable", {6'h00, irq_high, irq_low}, 8'h00);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h80);
    repeat (3) @(posedge clk_sys);
    check("wake to vector", {6'h00, wake, vector}, 8'h03);
    sleeping <= 1'b0;
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h00);
    wr_reg(irq_pkg::ADDR_THIRD_CTL, 8'h50);
    wr_reg(irq_pkg::ADDR_PERIPH_EN, 8'h01);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'h80);
    @(posedge clk_sys);
    check("peripheral_irq_enable off", {7'h00, irq_high}, 8'h00);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'hc0);
    @(posedge clk_sys);
    check("peripheral_irq_enable on", {7'h00, irq_high}, 8'h01);
    wr_reg(irq_pkg::ADDR_PERIPH_EN, 8'h00);
    wr_reg(irq_pkg::ADDR_RESET_CTL, 8'h80);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'hc0);
    ext_pin[2] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("low level source", {6'h00, irq_high, irq_low}, 8'h01);
    wr_reg(irq_pkg::ADDR_MAIN_CTL, 8'hd0);
    ext_pin[0] <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("pin zero high", {7'h00, irq_high}, 8'h01);
    delay  <= 4'h3;
    accept <= 1'b1;
    wait_ack();
    check("high first", {6'h00, ack, irq_high}, 8'h03);
    repeat (3) @(posedge clk_sys);
    check("low held off", {7'h00, irq_low}, 8'h00);
    finish_test();
  end

  initial begin
    #100us;
    mismatches++;
    finish_test();
  end
endmodule
